// ===== core/mdpf_pkg.sv
// Constants and types for the multidrop poll framer station
// Functional notes
// - Frames open with 02h, close with 03h
// - Count field covers count, ID, payload, checksum
// - Station ID two decimal digits, 01 to 31
// - Checksum XOR of count, ID, payload chars
// - Replies use the same framed format
// - One-character commands only poll and clear; poll count 008
// - Poll with data returns oldest, awaits clear
// - Poll when empty returns empty, no await
// - Poll when full: overflow reply, flush, await
// - Repeated poll while awaiting resends same reply (item or overflow)
// - Clear while awaiting acknowledges, removes one unless awaiting after overflow
// - Clear when not awaiting gets refused reply
// - Wrong ID, format or checksum: silence
// - Buffer overrun halts reading until trigger
// - Direct commands answered acknowledge or error
// - Invalid poll/clear characters give error reply
package mdpf_pkg;
   localparam logic [7:0] MDPF_STX = 8'h02;
   localparam logic [7:0] MDPF_ETX = 8'h03;
   localparam logic [7:0] MDPF_CH_POLL = 8'h50;
   localparam logic [7:0] MDPF_CH_CLEAR = 8'h43;
   localparam logic [7:0] MDPF_CH_ZERO = 8'h30;
   localparam logic [7:0] MDPF_CH_NINE = 8'h39;
   localparam logic [7:0] MDPF_CH_UA = 8'h41;
   localparam logic [7:0] MDPF_CH_UF = 8'h46;
   localparam logic [7:0] MDPF_CH_LA = 8'h61;
   localparam logic [7:0] MDPF_CH_LF = 8'h66;
   localparam logic [7:0] MDPF_CH_EMPTY = 8'h65;
   localparam logic [31:0] MDPF_TXT_OVER = 32'h4f564552;
   localparam logic [15:0] MDPF_TXT_ACK = 16'h4f4b;
   localparam logic [15:0] MDPF_TXT_REFUSED = 16'h4e47;
   localparam logic [23:0] MDPF_TXT_ERR = 24'h455252;
   // Count, ID and checksum characters around the payload
   localparam logic [7:0] MDPF_OVERHEAD = 8'h07;
   localparam logic [7:0] MDPF_POLL_COUNT = 8'h08;
   localparam logic [6:0] MDPF_ID_MIN = 7'h01;
   localparam logic [6:0] MDPF_ID_MAX = 7'h1f;
   // Positions of fields within the characters between the delimiters
   localparam logic [7:0] MDPF_POS_ID = 8'h03;
   localparam logic [7:0] MDPF_POS_PAY = 8'h05;
   typedef enum {RPL_DATA, RPL_EMPTY, RPL_OVER, RPL_ACK, RPL_REFUSED, RPL_ERR} mdpf_reply_t;
   typedef enum {ST_LISTEN, ST_CMD, ST_SEND} mdpf_state_t;
endpackage

// ===== core/mdpf_fifo.sv
// Read data buffer between the reading engine and the poll responder
`timescale 1ns/1ps
module mdpf_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   // Honest flags straight from the occupancy count
   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i && in_ready_o && !flush_i;
   assign pop = out_valid_o && out_ready_i && !flush_i;

   // Storage array, written only on accepted words
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end

   // Pointers and count; flush drops everything at once
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (flush_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== core/mdpf_station.sv
// Station-side multidrop poll framer: frame parser, poll/clear responder, reply framer
`timescale 1ns/1ps
module mdpf_station #(
   parameter int ITEM_CHARS = 4,
   parameter int FIFO_DEPTH = 4,
   parameter logic [15:0] ERR_PAYLOAD_CODE = 16'h3030,
   parameter logic [15:0] ERR_CMD_CODE = 16'h3031
) (
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic [4:0] STATION_ID_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic RX_VALID_I,
   output logic [7:0] TX_DATA_O,
   output logic TX_VALID_O,
   input wire logic TX_READY_I,
   output logic TX_DRIVE_O,
   input wire logic [8*ITEM_CHARS-1:0] ITEM_DATA_I,
   input wire logic ITEM_VALID_I,
   output logic ITEM_READY_O,
   input wire logic TRIGGER_I,
   output logic READ_HALTED_O,
   output logic AWAIT_CLEAR_O,
   output logic CMD_REQ_O,
   output logic [7:0] CMD_CODE_O,
   input wire logic CMD_DONE_I,
   input wire logic CMD_FAIL_I
);
   import mdpf_pkg::*;

   localparam int IW = 8 * ITEM_CHARS;

   logic rst_s1_reg;
   logic rst_n;
   logic trg_s1_reg;
   logic trg_s2_reg;
   logic trg_s3_reg;
   logic trg_level_reg;
   logic trg_rise;
   mdpf_state_t state_reg;
   mdpf_reply_t kind_reg;
   logic await_reg;
   logic await_over_reg;
   logic [IW-1:0] item_reg;
   logic [15:0] err_reg;
   logic pop_reg;
   logic flush_reg;
   logic halted_reg;
   logic item_ready_reg;
   logic cmd_req_reg;
   logic [7:0] cmd_code_reg;
   logic rx_act_reg;
   logic [7:0] rx_n_reg;
   logic [7:0] rx_xor_reg;
   logic [7:0] rx_h0_reg;
   logic [7:0] rx_h1_reg;
   logic [9:0] rx_cnt_reg;
   logic [6:0] rx_id_reg;
   logic rx_fmt_reg;
   logic [7:0] rx_pay_reg;
   logic [7:0] tx_idx_reg;
   logic [7:0] tx_xor_reg;
   logic [7:0] tx_data_reg;
   logic tx_valid_reg;
   logic tx_drive_reg;
   logic rx_take;
   logic frame_end;
   logic frame_ok;
   logic [7:0] pay_len;
   logic [7:0] tx_last;
   logic tx_step;
   logic tx_done;
   logic [7:0] tx_byte;
   logic fifo_in_ready;
   logic [IW-1:0] fifo_head;
   logic fifo_has;

   // ASCII decimal digit test
   function automatic logic is_dig(input logic [7:0] c);
      return (c >= MDPF_CH_ZERO) && (c <= MDPF_CH_NINE);
   endfunction

   // ASCII hex character value, bit 4 flags a valid character
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      logic [7:0] d;
      d = 8'h00;
      if (is_dig(c)) begin
         d = c - MDPF_CH_ZERO;
         return {1'b1, d[3:0]};
      end else if (c >= MDPF_CH_UA && c <= MDPF_CH_UF) begin
         d = c - MDPF_CH_UA + 8'h0a;
         return {1'b1, d[3:0]};
      end else if (c >= MDPF_CH_LA && c <= MDPF_CH_LF) begin
         d = c - MDPF_CH_LA + 8'h0a;
         return {1'b1, d[3:0]};
      end
      return 5'h00;
   endfunction

   // Upper-case hex character for a nibble
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'ha) ? MDPF_CH_ZERO + {4'h0, n} : MDPF_CH_UA + {4'h0, n} - 8'h0a;
   endfunction

   // Decimal digit character: pos 0 ones, 1 tens, 2 hundreds
   function automatic logic [7:0] dec_char(input logic [7:0] v, input logic [1:0] pos);
      logic [7:0] q;
      q = v;
      if (pos == 2'd1) begin
         q = v / 8'd10;
      end else if (pos == 2'd2) begin
         q = v / 8'd100;
      end
      return MDPF_CH_ZERO + (q % 8'd10);
   endfunction

   // Payload length of each reply kind
   function automatic logic [7:0] reply_len(input mdpf_reply_t k);
      case (k)
         RPL_DATA: return 8'(ITEM_CHARS);
         RPL_EMPTY: return 8'h01;
         RPL_OVER: return 8'h04;
         RPL_ERR: return 8'h05;
         default: return 8'h02;
      endcase
   endfunction

   // Payload character i of the reply being sent
   function automatic logic [7:0] reply_char(input mdpf_reply_t k, input logic [7:0] i,
                                             input logic [IW-1:0] item, input logic [15:0] code);
      logic [39:0] err;
      err = {MDPF_TXT_ERR, code};
      case (k)
         RPL_DATA: return item[IW-8-8*i +: 8];
         RPL_EMPTY: return MDPF_CH_EMPTY;
         RPL_OVER: return MDPF_TXT_OVER[24-8*i +: 8];
         RPL_ACK: return MDPF_TXT_ACK[8-8*i +: 8];
         RPL_REFUSED: return MDPF_TXT_REFUSED[8-8*i +: 8];
         default: return err[32-8*i +: 8];
      endcase
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // Timing input pin: three flops, a change counts once stages two and three agree
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         trg_s1_reg <= 1'b0;
         trg_s2_reg <= 1'b0;
         trg_s3_reg <= 1'b0;
         trg_level_reg <= 1'b0;
      end else begin
         trg_s1_reg <= TRIGGER_I;
         trg_s2_reg <= trg_s1_reg;
         trg_s3_reg <= trg_s2_reg;
         if (trg_s2_reg == trg_s3_reg) begin
            trg_level_reg <= trg_s3_reg;
         end
      end
   end
   assign trg_rise = trg_s2_reg && trg_s3_reg && !trg_level_reg;

   // Read data buffer; back-pressure reaches the reading engine
   mdpf_fifo #(.WIDTH(IW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(REF_CLK_I),
      .rst_n_i(rst_n),
      .flush_i(flush_reg),
      .in_data_i(ITEM_DATA_I),
      .in_valid_i(ITEM_VALID_I && item_ready_reg),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_head),
      .out_valid_o(fifo_has),
      .out_ready_i(pop_reg)
   );

   // halt on overrun
   // An item offered against a full buffer stops reading; a trigger restarts it, set wins
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         halted_reg <= 1'b0;
         item_ready_reg <= 1'b0;
      end else begin
         if (ITEM_VALID_I && !fifo_in_ready) begin
            halted_reg <= 1'b1;
         end else if (trg_rise) begin
            halted_reg <= 1'b0;
         end
         item_ready_reg <= fifo_in_ready && !halted_reg && !(ITEM_VALID_I && !fifo_in_ready);
      end
   end

   // Receiver listens only between replies; the driver's own echo is not parsed
   assign rx_take = RX_VALID_I && (state_reg == ST_LISTEN);

   // frame delimiting
   // STX always restarts the parser, so a torn frame cannot poison the next one
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         rx_act_reg <= 1'b0;
         rx_n_reg <= 8'h00;
         rx_xor_reg <= 8'h00;
         rx_h0_reg <= 8'h00;
         rx_h1_reg <= 8'h00;
         rx_cnt_reg <= 10'h000;
         rx_id_reg <= 7'h00;
         rx_fmt_reg <= 1'b0;
         rx_pay_reg <= 8'h00;
      end else if (rx_take) begin
         if (RX_DATA_I == MDPF_STX) begin
            rx_act_reg <= 1'b1;
            rx_n_reg <= 8'h00;
            rx_xor_reg <= 8'h00;
            rx_cnt_reg <= 10'h000;
            rx_id_reg <= 7'h00;
            rx_fmt_reg <= 1'b1;
         end else if (RX_DATA_I == MDPF_ETX) begin
            rx_act_reg <= 1'b0;
         end else if (rx_act_reg) begin
            rx_n_reg <= (rx_n_reg == 8'hff) ? rx_n_reg : rx_n_reg + 8'h01;
            rx_xor_reg <= rx_xor_reg ^ RX_DATA_I;
            rx_h1_reg <= rx_h0_reg;
            rx_h0_reg <= RX_DATA_I;
            if (rx_n_reg < MDPF_POS_ID) begin
               rx_fmt_reg <= rx_fmt_reg && is_dig(RX_DATA_I);
               rx_cnt_reg <= 10'(rx_cnt_reg * 10) + 10'(RX_DATA_I - MDPF_CH_ZERO);
            end else if (rx_n_reg < MDPF_POS_PAY) begin
               rx_fmt_reg <= rx_fmt_reg && is_dig(RX_DATA_I);
               rx_id_reg <= 7'(rx_id_reg * 10) + 7'(RX_DATA_I - MDPF_CH_ZERO);
            end else if (rx_n_reg == MDPF_POS_PAY) begin
               rx_pay_reg <= RX_DATA_I;
            end
         end
      end
   end

   // silent discard
   // Count, ID, format and checksum must all hold or the frame is dropped unanswered
   assign frame_end = rx_take && rx_act_reg && (RX_DATA_I == MDPF_ETX);
   assign pay_len = rx_n_reg - MDPF_OVERHEAD;
   always_comb begin
      logic [4:0] hi;
      logic [4:0] lo;
      hi = hex_val(rx_h1_reg);
      lo = hex_val(rx_h0_reg);
      frame_ok = rx_fmt_reg && (rx_n_reg >= MDPF_POLL_COUNT) && (rx_cnt_reg == {2'b00, rx_n_reg})
         && (rx_id_reg == {2'b00, STATION_ID_I}) && (rx_id_reg >= MDPF_ID_MIN)
         && (rx_id_reg <= MDPF_ID_MAX) && hi[4] && lo[4]
         && ({hi[3:0], lo[3:0]} == (rx_xor_reg ^ rx_h1_reg ^ rx_h0_reg));
   end

   // Responder: decides the reply and owns the awaiting-clear state
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_LISTEN;
         kind_reg <= RPL_EMPTY;
         await_reg <= 1'b0;
         await_over_reg <= 1'b0;
         item_reg <= '0;
         err_reg <= ERR_PAYLOAD_CODE;
         pop_reg <= 1'b0;
         flush_reg <= 1'b0;
         cmd_req_reg <= 1'b0;
         cmd_code_reg <= 8'h00;
      end else begin
         pop_reg <= 1'b0;
         flush_reg <= 1'b0;
         cmd_req_reg <= 1'b0;
         case (state_reg)
            ST_LISTEN: begin
               if (frame_end && frame_ok) begin
                  state_reg <= ST_SEND;
                  if (pay_len == 8'h01 && rx_pay_reg == MDPF_CH_POLL) begin
                     if (await_reg) begin
                        kind_reg <= await_over_reg ? RPL_OVER : RPL_DATA;
                     end else if (!fifo_in_ready) begin
                        kind_reg <= RPL_OVER;
                        flush_reg <= 1'b1;
                        await_reg <= 1'b1;
                        await_over_reg <= 1'b1;
                     end else if (fifo_has) begin
                        kind_reg <= RPL_DATA;
                        item_reg <= fifo_head;
                        await_reg <= 1'b1;
                        await_over_reg <= 1'b0;
                     end else begin
                        kind_reg <= RPL_EMPTY;
                     end
                  end else if (pay_len == 8'h01 && rx_pay_reg == MDPF_CH_CLEAR) begin
                     if (await_reg) begin
                        // remove one item; after overflow the buffer was already emptied
                        kind_reg <= RPL_ACK;
                        pop_reg <= !await_over_reg;
                        await_reg <= 1'b0;
                        await_over_reg <= 1'b0;
                     end else begin
                        kind_reg <= RPL_REFUSED;
                     end
                  end else if (pay_len == 8'h01) begin
                     kind_reg <= RPL_ERR;
                     err_reg <= ERR_PAYLOAD_CODE;
                  end else begin
                     state_reg <= ST_CMD;
                     cmd_req_reg <= 1'b1;
                     cmd_code_reg <= rx_pay_reg;
                  end
               end
            end
            ST_CMD: begin
               if (CMD_DONE_I) begin
                  state_reg <= ST_SEND;
                  kind_reg <= CMD_FAIL_I ? RPL_ERR : RPL_ACK;
                  err_reg <= ERR_CMD_CODE;
               end
            end
            ST_SEND: begin
               if (tx_done) begin
                  state_reg <= ST_LISTEN;
               end
            end
            default: state_reg <= ST_LISTEN;
         endcase
      end
   end

   // reply framing
   // Byte order: STX, count, ID, payload, checksum, ETX
   assign tx_last = reply_len(kind_reg) + 8'h08;
   assign tx_step = (state_reg == ST_SEND) && (!tx_valid_reg || TX_READY_I);
   assign tx_done = tx_step && (tx_idx_reg > tx_last);
   always_comb begin
      logic [7:0] pl;
      pl = reply_len(kind_reg);
      if (tx_idx_reg == 8'h00) begin
         tx_byte = MDPF_STX;
      end else if (tx_idx_reg <= 8'h03) begin
         tx_byte = dec_char(pl + MDPF_OVERHEAD, 2'(8'h03 - tx_idx_reg));
      end else if (tx_idx_reg <= 8'h05) begin
         tx_byte = dec_char({3'b000, STATION_ID_I}, 2'(8'h05 - tx_idx_reg));
      end else if (tx_idx_reg <= pl + 8'h05) begin
         tx_byte = reply_char(kind_reg, tx_idx_reg - 8'h06, item_reg, err_reg);
      end else if (tx_idx_reg == pl + 8'h06) begin
         tx_byte = hex_char(tx_xor_reg[7:4]);
      end else if (tx_idx_reg == pl + 8'h07) begin
         tx_byte = hex_char(tx_xor_reg[3:0]);
      end else begin
         tx_byte = MDPF_ETX;
      end
   end

   // Transmit byte stream; checksum accumulates over count, ID and payload
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         tx_idx_reg <= 8'h00;
         tx_xor_reg <= 8'h00;
         tx_data_reg <= 8'h00;
         tx_valid_reg <= 1'b0;
         tx_drive_reg <= 1'b0;
      end else begin
         tx_drive_reg <= (state_reg == ST_SEND) && !tx_done;
         if (state_reg != ST_SEND) begin
            tx_idx_reg <= 8'h00;
            tx_xor_reg <= 8'h00;
         end else if (tx_step) begin
            if (tx_idx_reg <= tx_last) begin
               tx_data_reg <= tx_byte;
               tx_valid_reg <= 1'b1;
               tx_idx_reg <= tx_idx_reg + 8'h01;
               if (tx_idx_reg != 8'h00 && tx_idx_reg <= reply_len(kind_reg) + 8'h05) begin
                  tx_xor_reg <= tx_xor_reg ^ tx_byte;
               end
            end else begin
               tx_valid_reg <= 1'b0;
            end
         end
      end
   end

   // Outputs all straight from flops
   assign TX_DATA_O = tx_data_reg;
   assign TX_VALID_O = tx_valid_reg;
   assign TX_DRIVE_O = tx_drive_reg;
   assign ITEM_READY_O = item_ready_reg;
   assign READ_HALTED_O = halted_reg;
   assign AWAIT_CLEAR_O = await_reg;
   assign CMD_REQ_O = cmd_req_reg;
   assign CMD_CODE_O = cmd_code_reg;
endmodule

// ===== tb/mdpf_station_assertions.sv
// Port checker for the multidrop poll framer station
`timescale 1ns/1ps
module mdpf_station_assertions
   import mdpf_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic RX_VALID_I,
   input wire logic [7:0] TX_DATA_O,
   input wire logic TX_VALID_O,
   input wire logic TX_READY_I,
   input wire logic TX_DRIVE_O,
   input wire logic ITEM_READY_O,
   input wire logic TRIGGER_I,
   input wire logic READ_HALTED_O,
   input wire logic AWAIT_CLEAR_O,
   input wire logic CMD_REQ_O,
   input wire logic CMD_DONE_I
);
   logic [3:0] quiet_reg;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!NRST_I);
   // Cycles since the trigger pin was last high, saturating
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) quiet_reg <= 4'h0;
      else if (TRIGGER_I) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
   end
   a_reply_opens_stx: assert property ($rose(TX_DRIVE_O) |-> TX_VALID_O && TX_DATA_O == MDPF_STX)
      else $error("reply did not open with start byte");
   a_etx_ends_drive: assert property (TX_VALID_O && TX_READY_I && TX_DATA_O == MDPF_ETX |=> !TX_VALID_O ##1 !TX_DRIVE_O)
      else $error("driver not released after end byte");
   a_drive_covers_tx: assert property (TX_VALID_O |-> TX_DRIVE_O)
      else $error("character offered with driver off");
   a_char_held_stall: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
      else $error("reply character changed while stalled");
   a_reply_has_cause: assert property ($rose(TX_DRIVE_O) |-> $past(RX_VALID_I && RX_DATA_I == MDPF_ETX, 2)
      || $past(RX_VALID_I && RX_DATA_I == MDPF_ETX, 3) || $past(CMD_DONE_I, 2) || $past(CMD_DONE_I, 3))
      else $error("reply without a received frame");
   a_halt_blocks_item: assert property (READ_HALTED_O ##1 READ_HALTED_O |-> !ITEM_READY_O)
      else $error("items accepted while reading halted");
   a_halt_until_trig: assert property (READ_HALTED_O && quiet_reg > 4'h6 |=> READ_HALTED_O)
      else $error("halt left without trigger");
   a_await_near_reply: assert property ($changed(AWAIT_CLEAR_O) |-> ##[0:3] TX_DRIVE_O)
      else $error("await state changed away from a reply");
   a_cmd_req_pulse: assert property (CMD_REQ_O |=> !CMD_REQ_O)
      else $error("command request longer than one cycle");
   c_await: cover property ($rose(AWAIT_CLEAR_O));
   c_halt: cover property ($rose(READ_HALTED_O));
   c_cmd: cover property (CMD_REQ_O);
endmodule
bind mdpf_station mdpf_station_assertions u_chk (.REF_CLK_I, .NRST_I, .RX_DATA_I, .RX_VALID_I, .TX_DATA_O,
   .TX_VALID_O, .TX_READY_I, .TX_DRIVE_O, .ITEM_READY_O, .TRIGGER_I, .READ_HALTED_O, .AWAIT_CLEAR_O,
   .CMD_REQ_O, .CMD_DONE_I);

// ===== tb/mdpf_host.sv
// Host model for the multidrop link: sends framed commands, collects replies
`timescale 1ns/1ps
module mdpf_host (
   input wire logic clk_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   input wire logic tx_drive_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o
);
   logic [7:0] got[$];
   bit slow = 1'b0;
   bit ph = 1'b0;
   // Skew corrupts the count field; lower sends lower-case checksum letters
   bit skew = 1'b0;
   bit lower = 1'b0;
   function automatic logic [7:0] dg(input int v);
      return 8'(8'h30 + v % 10);
   endfunction
   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'ha) ? 8'(8'h30 + v) : 8'(8'h37 + v);
   endfunction
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b0;
   end
   // Slow mode stalls every other cycle so the reply must hold
   // echo is not compared, the link never collides here
   always @(posedge clk_i) begin
      ph <= ~ph;
      tx_ready_o <= ~slow | ph;
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
   end
   // frame build, bad forces a checksum error
   task automatic send(input int id, input logic [63:0] p, input int n, input bit bad);
      logic [7:0] f[$];
      logic [7:0] x;
      f = {dg((n + 7 + skew) / 100), dg((n + 7 + skew) / 10), dg(n + 7 + skew), dg(id / 10), dg(id)};
      for (int i = n - 1; i >= 0; i--) f.push_back(p[8*i+:8]);
      x = 8'h00;
      foreach (f[i]) x ^= f[i];
      if (bad) x = ~x;
      f.push_back(hx(x[7:4]) | {2'b00, lower, 5'h00});
      f.push_back(hx(x[3:0]) | {2'b00, lower, 5'h00});
      f.push_front(8'h02);
      f.push_back(8'h03);
      foreach (f[i]) begin
         @(posedge clk_i);
         rx_data_o <= f[i];
         rx_valid_o <= 1'b1;
         @(posedge clk_i);
         rx_data_o <= ~f[i];
         rx_valid_o <= 1'b0;
      end
   endtask
   // one frame outstanding: wait for reply end or timeout
   task automatic recv(input int id, output logic [95:0] pay, output bit ok);
      int w;
      int n;
      logic [7:0] x;
      got.delete();
      pay = '0;
      ok = 1'b0;
      w = 0;
      while (!(got.size() > 0 && got[$] == 8'h03) && w < 300) begin
         @(posedge clk_i);
         w++;
      end
      while (tx_drive_i !== 1'b0 && w < 600) begin
         @(posedge clk_i);
         w++;
      end
      n = got.size();
      if (n < 8) return;
      x = 8'h00;
      for (int i = 1; i < n - 3; i++) x ^= got[i];
      ok = got[0] === 8'h02 && got[n-1] === 8'h03 && got[1] === dg((n - 2) / 100) && got[2] === dg((n - 2) / 10)
         && got[3] === dg(n - 2) && got[4] === dg(id / 10) && got[5] === dg(id) && got[n-3] === hx(x[7:4])
         && got[n-2] === hx(x[3:0]);
      for (int i = 6; i < n - 3; i++) pay = {pay[87:0], got[i]};
   endtask
endmodule

// ===== tb/multidrop_poll_framer_tb_top.sv
// Self-checking bench for the multidrop poll framer station
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module multidrop_poll_framer_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] rx_data, tx_data, cmd_code, last_code;
   logic rx_valid, tx_valid, tx_ready, tx_drive, item_ready, halted, await_clear, cmd_req;
   logic item_valid = 1'b0, trigger = 1'b0, cmd_done = 1'b0, cmd_fail = 1'b0, fail_sel = 1'b0;
   logic [31:0] item_data = 32'h0;
   logic [95:0] got;
   bit ok;
   int err_total = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   mdpf_station DUT (.REF_CLK_I(clk), .NRST_I(nrst), .STATION_ID_I(5'd7), .RX_DATA_I(rx_data),
      .RX_VALID_I(rx_valid), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
      .TX_DRIVE_O(tx_drive), .ITEM_DATA_I(item_data), .ITEM_VALID_I(item_valid), .ITEM_READY_O(item_ready),
      .TRIGGER_I(trigger), .READ_HALTED_O(halted), .AWAIT_CLEAR_O(await_clear), .CMD_REQ_O(cmd_req),
      .CMD_CODE_O(cmd_code), .CMD_DONE_I(cmd_done), .CMD_FAIL_I(cmd_fail));
   mdpf_host u_host (.clk_i(clk), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_drive_i(tx_drive),
      .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid));
   // Command engine stand-in, finishes one cycle after each request
   always @(posedge clk) begin
      cmd_done <= cmd_req;
      cmd_fail <= cmd_req & fail_sel;
      if (cmd_req) last_code <= cmd_code;
   end
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hold the item until ready is seen, ready is looked at mid-cycle
   task automatic push(input logic [31:0] d);
      int w;
      w = 0;
      @(posedge clk);
      item_data <= d;
      item_valid <= 1'b1;
      @(negedge clk);
      while (item_ready !== 1'b1 && w < 50) begin
         @(negedge clk);
         w++;
      end
      `CHK("item ready", 1'b1, item_ready);
      @(posedge clk);
      item_valid <= 1'b0;
   endtask
   task automatic xact(input logic [63:0] p, input int n, input logic [95:0] e, input logic aw);
      u_host.send(7, p, n, 1'b0);
      u_host.recv(7, got, ok);
      `CHK("frame", 1'b1, ok);
      `CHK("payload", e, got);
      `CHK("await", aw, await_clear);
   endtask
   task automatic t_data;
      u_host.slow = 1'b1;
      xact("P", 1, "e", 1'b0);
      xact("C", 1, "NG", 1'b0);
      push(32'h41424344);
      push(32'h45464748);
      xact("P", 1, "ABCD", 1'b1);
      xact("P", 1, "ABCD", 1'b1);
      xact("C", 1, "OK", 1'b0);
      xact("C", 1, "NG", 1'b0);
      xact("P", 1, "EFGH", 1'b1);
      xact("C", 1, "OK", 1'b0);
      u_host.slow = 1'b0;
      $display("test data done");
   endtask
   task automatic t_silence;
      u_host.send(9, "P", 1, 1'b0);
      u_host.recv(9, got, ok);
      `CHK("other id", 96'h0, got);
      u_host.send(7, "P", 1, 1'b1);
      u_host.recv(7, got, ok);
      `CHK("bad sum", 96'h0, got);
      u_host.skew = 1'b1;
      u_host.send(7, "P", 1, 1'b0);
      u_host.skew = 1'b0;
      u_host.recv(7, got, ok);
      `CHK("bad count", 96'h0, got);
      u_host.lower = 1'b1;
      xact("P", 1, "e", 1'b0);
      u_host.lower = 1'b0;
      $display("test silence done");
   endtask
   task automatic t_over;
      for (int i = 0; i < 4; i++) push(32'h51525330 + i);
      @(posedge clk);
      item_valid <= 1'b1;
      repeat (3) @(posedge clk);
      item_valid <= 1'b0;
      @(negedge clk);
      `CHK("halted", 1'b1, halted);
      `CHK("ready", 1'b0, item_ready);
      xact("P", 1, "OVER", 1'b1);
      xact("P", 1, "OVER", 1'b1);
      xact("C", 1, "OK", 1'b0);
      xact("P", 1, "e", 1'b0);
      trigger <= 1'b1;
      repeat (3) @(posedge clk);
      trigger <= 1'b0;
      repeat (8) @(negedge clk);
      `CHK("resumed", 1'b0, halted);
      push(32'h41414141);
      xact("P", 1, "AAAA", 1'b1);
      xact("C", 1, "OK", 1'b0);
      $display("test overflow done");
   endtask
   task automatic t_cmd;
      xact("X", 1, "ERR00", 1'b0);
      xact("LOAD", 4, "OK", 1'b0);
      `CHK("cmd code", 8'h4c, last_code);
      fail_sel <= 1'b1;
      xact("LOAD", 4, "ERR01", 1'b0);
      $display("test command done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      t_data();
      t_silence();
      t_over();
      t_cmd();
      end_sim();
   end
   // Watchdog well beyond the expected run of some 2000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule
